// ==== design/capture_pkg.sv ====
// Constants, field layouts and carrier types of the input capture channel
package capture_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CON1 = 8'h00;
  localparam logic [7:0] OFS_CON2 = 8'h04;
  localparam logic [7:0] OFS_BUF  = 8'h08;
  localparam logic [7:0] OFS_TMR  = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int TSEL_LSB  = 10;
  localparam int ICI_LSB   = 5;
  localparam int OV_BIT    = 4;
  localparam int BNE_BIT   = 3;
  localparam int MODE_LSB  = 0;
  localparam int TRIG_BIT  = 7;
  localparam int TSTAT_BIT = 6;
  localparam int SYNC_LSB  = 0;
  localparam int ST_CAP    = 0;
  localparam int ST_OV     = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Codes and values after reset
  localparam logic [2:0] TSEL_PERIPH = 3'h7;
  localparam logic [2:0] TSEL_T1     = 3'h4;
  localparam logic [2:0] TSEL_T2     = 3'h1;
  localparam logic [2:0] TSEL_RST    = 3'h0;
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_BOTH   = 3'h1;
  localparam logic [2:0] MODE_FALL   = 3'h2;
  localparam logic [2:0] MODE_RISE   = 3'h3;
  localparam logic [2:0] MODE_PRE4   = 3'h4;
  localparam logic [2:0] MODE_PRE16  = 3'h5;
  localparam logic [2:0] MODE_PIN    = 3'h7;
  localparam logic [4:0] SRC_NONE0   = 5'h00;
  localparam logic [4:0] SRC_OC      = 5'h01;
  localparam logic [4:0] SRC_T1      = 5'h0B;
  localparam logic [4:0] SRC_T2      = 5'h0C;
  localparam logic [4:0] SRC_T3      = 5'h0D;
  localparam logic [4:0] SRC_COMPARATOR_ONE    = 5'h18;
  localparam logic [4:0] SRC_COMPARATOR_TWO    = 5'h19;
  localparam logic [4:0] SRC_NONE1   = 5'h1F;
  localparam logic [4:0] SYNC_RST    = SRC_T3;
  localparam logic [3:0] PRE4_LAST   = 4'h3;
  localparam logic [3:0] PRE16_LAST  = 4'hF;
  localparam int         FIFO_DEPTH  = 4;
  localparam int         DATA_W      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic [2:0] tsel;
    logic [1:0] captures_per_interrupt;
    logic [2:0] mode;
  } con1_t;

  typedef struct packed {
    logic       trig_op;
    logic       trig_stat;
    logic [4:0] sync_sel;
  } con2_t;

  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic oc;
    logic comparator_one;
    logic comparator_two;
  } src_evt_t;

endpackage : capture_pkg

// ==== design/edge_prescaler.sv ====
// Edge detector and capture prescaler for the capture input
`timescale 1ns/1ps
`default_nettype none
module edge_prescaler
  import capture_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Input and mode
  input  wire logic       cap_in,
  input  wire logic [2:0] mode,
  // Events
  output logic            cap_evt,
  output logic            pin_evt
);

  logic       prev_reg, prev_next;
  logic [3:0] pre_reg, pre_next;
  logic       rise, fall;

  always_comb begin
    rise      = cap_in & ~prev_reg;
    fall      = ~cap_in & prev_reg;
    prev_next = cap_in;
    pre_next  = pre_reg;
    cap_evt   = 1'b0;
    pin_evt   = 1'b0;
    unique case (mode)
      MODE_BOTH: cap_evt = rise | fall;
      MODE_FALL: cap_evt = fall;
      MODE_RISE: cap_evt = rise;
      MODE_PRE4, MODE_PRE16: begin
        if (rise) begin
          if (pre_reg == ((mode == MODE_PRE4) ? PRE4_LAST : PRE16_LAST)) begin
            cap_evt  = 1'b1;
            pre_next = 4'h0;
          end else begin
            pre_next = pre_reg + 4'h1;
          end
        end
      end
      MODE_PIN: pin_evt = rise;
      default: pre_next = 4'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= 1'b0;
      pre_reg  <= 4'h0;
    end else begin
      prev_reg <= prev_next;
      pre_reg  <= pre_next;
    end
  end

endmodule : edge_prescaler
`default_nettype wire

// ==== design/capture_fifo.sv ====
// Four-entry first-in first-out store of captured timer values
`timescale 1ns/1ps
`default_nettype none
module capture_fifo
  import capture_pkg::*;
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // Control
  input  wire logic              push,
  input  wire logic              pop,
  input  wire logic              flush,
  input  wire logic [DATA_W-1:0] din,
  // State
  output logic      [DATA_W-1:0] head,
  output logic      [2:0]        count
);

  logic [DATA_W-1:0] mem_reg [FIFO_DEPTH];
  logic [DATA_W-1:0] mem_next [FIFO_DEPTH];
  logic [1:0]        wr_reg, wr_next, rd_reg, rd_next;
  logic [2:0]        cnt_reg, cnt_next;
  logic              do_push, do_pop;

  assign head  = mem_reg[rd_reg];
  assign count = cnt_reg;

  always_comb begin
    do_pop  = pop && (cnt_reg != 3'h0);
    do_push = push && ((cnt_reg != 3'h4) || do_pop);
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (flush) begin
      wr_next  = 2'h0;
      rd_next  = 2'h0;
      cnt_next = 3'h0;
    end else begin
      if (do_push) begin
        mem_next[wr_reg] = din;
        wr_next          = wr_reg + 2'h1;
      end
      if (do_pop) begin
        rd_next = rd_reg + 2'h1;
      end
      cnt_next = cnt_reg + {2'h0, do_push} - {2'h0, do_pop};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_reg[i] <= 16'h0000;
      end
      wr_reg  <= 2'h0;
      rd_reg  <= 2'h0;
      cnt_reg <= 3'h0;
    end else begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : capture_fifo
`default_nettype wire

// ==== design/input_capture_channel.sv ====
// Input capture channel with AHB-Lite register slave and interrupt
//
// Overview of operation
// - Time base clock chosen by three-bit select
// - Timer1 clock used only in synchronous form
// - Overflow flag set by hardware on overflow
// - Not-empty flag shows unread captured values
// - Prescaled modes capture every 16th/4th rise
// - Mode 000 turns capture off
// - Trigger bit one: source triggers timer
// - Trigger bit zero: source synchronizes timer
// - Source sets trigger status; timer then runs
// - Trigger bit one: status zero holds timer at zero
// - Software reads, sets, clears trigger status
// - Source codes 11111, 00000 select nothing
// - Codes select timer3 (default), timer2, timer1
// - Code 00001 selects output compare unit
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module input_capture_channel
  import capture_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Capture input and time base enables
  input  wire logic        cap_in,
  input  wire logic        timer1_clk_en,
  input  wire logic        timer2_clk_en,
  // Sync and trigger sources
  input  wire src_evt_t    src_evt,
  // Interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  con1_t       con1_reg, con1_next;
  con2_t       con2_reg, con2_next;
  logic        ov_reg, ov_next;
  logic [15:0] tmr_reg, tmr_next;
  logic [1:0]  icnt_reg, icnt_next;
  logic [1:0]  stat_reg, stat_next;
  logic [1:0]  mask_reg, mask_next;
  logic        wpend_reg, wpend_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] rdata_reg, rdata_next;

  logic        cap_evt, pin_evt, int_evt, tb_en, src_hit;
  logic        accept, pop, push, flush, full, ov_set;
  logic [15:0] head;
  logic [2:0]  count;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection and buffer
  edge_prescaler u_edge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cap_in  (cap_in),
    .mode    (con1_reg.mode),
    .cap_evt (cap_evt),
    .pin_evt (pin_evt)
  );

  capture_fifo u_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .push    (push),
    .pop     (pop),
    .flush   (flush),
    .din     (tmr_reg),
    .head    (head),
    .count   (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Time base and source selection
  function automatic logic pick_src(input logic [4:0] sel, input src_evt_t e);
    logic hit;
    hit = 1'b0;
    case (sel)
      SRC_T3:   hit = e.t3;
      SRC_T2:   hit = e.t2;
      SRC_T1:   hit = e.t1;
      SRC_OC:   hit = e.oc;
      SRC_COMPARATOR_ONE: hit = e.comparator_one;
      SRC_COMPARATOR_TWO: hit = e.comparator_two;
      default:  hit = 1'b0;
    endcase
    return hit;
  endfunction : pick_src

  always_comb begin
    unique case (con1_reg.tsel)
      TSEL_PERIPH: tb_en = 1'b1;
      TSEL_T1:     tb_en = timer1_clk_en;
      TSEL_T2:     tb_en = timer2_clk_en;
      default:     tb_en = 1'b0;
    endcase
    src_hit = pick_src(con2_reg.sync_sel, src_evt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture timer, buffer control and interrupt count
  always_comb begin
    flush     = (con1_reg.mode == MODE_OFF);
    full      = (count == 3'h4);
    push      = cap_evt && (!full || pop);
    ov_set    = cap_evt && full && !pop;
    tmr_next  = tmr_reg;
    icnt_next = icnt_reg;
    int_evt   = 1'b0;
    if (flush) begin
      tmr_next = 16'h0000;
    end else if (con2_reg.trig_op && !con2_reg.trig_stat) begin
      tmr_next = 16'h0000;
    end else if (!con2_reg.trig_op && src_hit) begin
      tmr_next = 16'h0000;
    end else if (tb_en) begin
      tmr_next = tmr_reg + 16'h0001;
    end
    if (flush) begin
      icnt_next = 2'h0;
    end else if (pin_evt) begin
      int_evt = 1'b1;
    end else if (cap_evt) begin
      if (con1_reg.mode == MODE_BOTH || icnt_reg == con1_reg.captures_per_interrupt) begin
        int_evt   = 1'b1;
        icnt_next = 2'h0;
      end else begin
        icnt_next = icnt_reg + 2'h1;
      end
    end
    // Set wins over the clear so a capture racing a drain is not lost
    ov_next = ov_reg;
    if (ov_set) begin
      ov_next = 1'b1;
    end else if (flush || (pop && count == 3'h1 && !push)) begin
      ov_next = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_reg  <= 16'h0000;
      icnt_reg <= 2'h0;
      ov_reg   <= 1'b0;
    end else begin
      tmr_reg  <= tmr_next;
      icnt_reg <= icnt_next;
      ov_reg   <= ov_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and software registers
  // A write stalls one cycle so a following read never sees stale data
  assign hreadyout = !wpend_reg;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;
  assign irq       = |(stat_reg & mask_reg);

  always_comb begin
    accept     = hsel && hready && htrans[1];
    wpend_next = accept && hwrite;
    waddr_next = accept ? haddr[7:0] : waddr_reg;
    pop        = accept && !hwrite && (haddr[7:0] == OFS_BUF);
    rdata_next = rdata_reg;
    if (accept && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CON1: rdata_next = {16'h0000, 3'h0, con1_reg.tsel, 3'h0,
                                con1_reg.captures_per_interrupt, ov_reg, (count != 3'h0),
                                con1_reg.mode};
        OFS_CON2: rdata_next = {24'h000000, con2_reg.trig_op,
                                con2_reg.trig_stat, 1'b0,
                                con2_reg.sync_sel};
        OFS_BUF:  rdata_next = (count != 3'h0) ? {16'h0000, head} : 32'h0000_0000;
        OFS_TMR:  rdata_next = {16'h0000, tmr_reg};
        OFS_STAT: rdata_next = {30'h0000_0000, stat_reg};
        OFS_MASK: rdata_next = {30'h0000_0000, mask_reg};
        default:  rdata_next = 32'h0000_0000;
      endcase
    end
    con1_next = con1_reg;
    con2_next = con2_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (wpend_reg) begin
      unique case (waddr_reg)
        OFS_CON1: con1_next = {hwdata[TSEL_LSB +: 3], hwdata[ICI_LSB +: 2],
                               hwdata[MODE_LSB +: 3]};
        OFS_CON2: con2_next = {hwdata[TRIG_BIT], hwdata[TSTAT_BIT],
                               hwdata[SYNC_LSB +: 5]};
        OFS_STAT: stat_next = stat_reg & ~hwdata[1:0];
        OFS_MASK: mask_next = hwdata[1:0];
        default:  ;
      endcase
    end
    if (con2_reg.trig_op && src_hit) begin
      con2_next.trig_stat = 1'b1;
    end
    if (int_evt) begin
      stat_next[ST_CAP] = 1'b1;
    end
    if (ov_set) begin
      stat_next[ST_OV] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      con1_reg  <= '{tsel: TSEL_RST, captures_per_interrupt: 2'h0, mode: MODE_OFF};
      con2_reg  <= '{trig_op: 1'b0, trig_stat: 1'b0, sync_sel: SYNC_RST};
      stat_reg  <= 2'h0;
      mask_reg  <= 2'h0;
      wpend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      con1_reg  <= con1_next;
      con2_reg  <= con2_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      wpend_reg <= wpend_next;
      waddr_reg <= waddr_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PERIPH_COUNT: assert property (
    (con1_reg.tsel == TSEL_PERIPH && !flush && !con2_reg.trig_op && !src_hit)
    |=> tmr_reg == $past(tmr_reg) + 16'h0001)
    else $error("peripheral clock time base did not count");

  AST_T1_GATED: assert property (
    (con1_reg.tsel == TSEL_T1 && !timer1_clk_en) |=> $stable(tmr_reg) || tmr_reg == 16'h0000)
    else $error("timer1 time base moved without its enable");

  AST_OVERFLOW: assert property (
    ov_set |=> ov_reg && stat_reg[ST_OV])
    else $error("overflow not flagged");

  AST_NOT_EMPTY: assert property (
    (push && count == 3'h0 && !flush) |=> count == 3'h1)
    else $error("capture not held in buffer");

  AST_PRE16_GAP: assert property (
    (cap_evt && con1_reg.mode == MODE_PRE16) |=> !cap_evt [*8])
    else $error("prescaled capture too soon");

  AST_OFF_FLUSH: assert property (
    (con1_reg.mode == MODE_OFF) |=> count == 3'h0 && tmr_reg == 16'h0000)
    else $error("capture not off in mode zero");

  AST_TRIG_SET: assert property (
    (con2_reg.trig_op && src_hit) |=> con2_reg.trig_stat)
    else $error("trigger did not set status");

  AST_TRIG_HOLD: assert property (
    (con2_reg.trig_op && !con2_reg.trig_stat) |=> tmr_reg == 16'h0000)
    else $error("timer not held while untriggered");

  AST_SYNC_CLEAR: assert property (
    (!con2_reg.trig_op && src_hit) |=> tmr_reg == 16'h0000)
    else $error("sync event did not clear timer");

  AST_NO_SOURCE: assert property (
    (con2_reg.sync_sel == SRC_NONE0 || con2_reg.sync_sel == SRC_NONE1) |-> !src_hit)
    else $error("source seen with none selected");

  AST_IRQ_LEVEL: assert property (
    int_evt |=> stat_reg[ST_CAP] ##0 (irq == mask_reg[ST_CAP] || stat_reg[ST_OV]))
    else $error("capture interrupt not raised");

  AST_BNE_READ: assert property (
    (accept && !hwrite && haddr[7:0] == OFS_CON1)
    |=> hrdata[BNE_BIT] == ($past(count) != 3'h0))
    else $error("not-empty flag read wrong");

  AST_OV_READ: assert property (
    (accept && !hwrite && haddr[7:0] == OFS_CON1) |=> hrdata[OV_BIT] == $past(ov_reg))
    else $error("overflow flag read wrong");

  AST_OV_HOLD: assert property (
    (ov_reg && !flush && !pop) |=> ov_reg)
    else $error("overflow flag lost without a read");

  AST_FIFO_OLDEST: assert property (
    (pop && count != 3'h0) |=> hrdata[15:0] == $past(head))
    else $error("buffer read not oldest value");

  AST_PRE4_GAP: assert property (
    (cap_evt && con1_reg.mode == MODE_PRE4) |=> !cap_evt [*6])
    else $error("prescaled capture too soon");

  AST_RISE_ONLY: assert property (
    (cap_evt && con1_reg.mode == MODE_RISE) |-> cap_in)
    else $error("rising mode captured a fall");

  AST_FALL_ONLY: assert property (
    (cap_evt && con1_reg.mode == MODE_FALL) |-> !cap_in)
    else $error("falling mode captured a rise");

  AST_PIN_NO_PUSH: assert property (
    (con1_reg.mode == MODE_PIN) |-> !push)
    else $error("pin mode wrote the buffer");

  AST_SW_TRIG: assert property (
    (wpend_reg && waddr_reg == OFS_CON2 && !(con2_reg.trig_op && src_hit))
    |=> con2_reg.trig_stat == $past(hwdata[TSTAT_BIT]))
    else $error("software write of trigger status lost");

  AST_SRC_T1: assert property (
    (con2_reg.sync_sel == SRC_T1) |-> src_hit == src_evt.t1)
    else $error("timer1 source not routed");

  AST_SRC_OC: assert property (
    (con2_reg.sync_sel == SRC_OC) |-> src_hit == src_evt.oc)
    else $error("output compare source not routed");

  AST_TB_RESERVED: assert property (
    (con1_reg.tsel != TSEL_PERIPH && con1_reg.tsel != TSEL_T1 && con1_reg.tsel != TSEL_T2)
    |=> $stable(tmr_reg) || tmr_reg == 16'h0000)
    else $error("reserved time base moved the timer");

  AST_IRQ_OUT: assert property (
    (stat_reg[ST_CAP] && mask_reg[ST_CAP]) |-> irq)
    else $error("unmasked capture status without interrupt");

  COV_SYNC_HIT:  cover property (!con2_reg.trig_op && src_hit);
  COV_OVERFLOW:  cover property (ov_set);
  COV_TRIGGER:   cover property (con2_reg.trig_op && src_hit ##1 tb_en);
  COV_FOUR_INT:  cover property (int_evt && con1_reg.captures_per_interrupt == 2'h3);
  COV_PIN_MODE:  cover property (pin_evt ##1 irq);

endmodule : input_capture_channel
`default_nettype wire

// ==== tb/capture_stimulus.sv ====
// Far-side model: capture input, timer clock ticks and source event pulses
`timescale 1ns/1ps
`default_nettype none
module capture_stimulus
  import capture_pkg::*;
(
  // Clock
  input  wire logic    hclk,
  // Far-side signals
  output logic         cap_in,
  output logic         timer1_clk_en,
  output logic         timer2_clk_en,
  output var src_evt_t src_evt
);
  logic [2:0] t1_cnt = 3'h0;
  logic [2:0] t2_cnt = 3'h0;

  initial begin
    cap_in  = 1'b0;
    src_evt = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periods of 4 and 5 give exact tick counts over 40-cycle spans
  always @(posedge hclk) begin
    t1_cnt <= (t1_cnt == 3'h3) ? 3'h0 : t1_cnt + 3'h1;
    t2_cnt <= (t2_cnt == 3'h4) ? 3'h0 : t2_cnt + 3'h1;
  end
  assign timer1_clk_en = (t1_cnt == 3'h0);
  assign timer2_clk_en = (t2_cnt == 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Rising edges spaced 2*half cycles; call just after a rising edge
  task automatic wave(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      cap_in <= 1'b1;
      repeat (half) @(posedge hclk);
      cap_in <= 1'b0;
      repeat (half) @(posedge hclk);
    end
  endtask : wave

  // One-cycle source pulse; the channel never feeds itself
  task automatic pulse(input logic [5:0] v);
    src_evt <= src_evt_t'(v);
    @(posedge hclk);
    src_evt <= '0;
    @(posedge hclk);
  endtask : pulse
endmodule : capture_stimulus
`default_nettype wire

// ==== tb/input_capture_channel_test.sv ====
// Self-checking testbench of the input capture channel
`timescale 1ns/1ps
`default_nettype none
module input_capture_channel_test;
  import capture_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        cap_in;
  logic        timer1_clk_en;
  logic        timer2_clk_en;
  src_evt_t    src_evt;
  logic        irq;
  logic        rdy;
  logic [31:0] rdq;
  int          fail_count = 0;
  int          checks_done = 0;
  logic [4:0]  codes [6] = '{SRC_T3, SRC_T2, SRC_T1, SRC_OC, SRC_COMPARATOR_ONE, SRC_COMPARATOR_TWO};
  logic [5:0]  evts [6] = '{6'h08, 6'h10, 6'h20, 6'h04, 6'h02, 6'h01};

  assign hready = hreadyout;
  always #50 hclk = ~hclk;

  input_capture_channel input_capture_channel_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cap_in(cap_in),
    .timer1_clk_en(timer1_clk_en), .timer2_clk_en(timer2_clk_en),
    .src_evt(src_evt), .irq(irq));

  capture_stimulus capture_stimulus_inst (
    .hclk(hclk), .cap_in(cap_in), .timer1_clk_en(timer1_clk_en),
    .timer2_clk_en(timer2_clk_en), .src_evt(src_evt));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Snapshot at the falling edge is what the next rising edge samples
  // No wait limit here: only the watchdog ends a hung transfer
  task automatic wait_rdy();
    do begin
      @(negedge hclk);
      rdy = hreadyout;
      rdq = hrdata;
      check({31'h0, hresp}, 32'h0);
      @(posedge hclk);
    end while (rdy !== 1'b1);
  endtask : wait_rdy

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(rdq & m, e);
  endtask : rchk

  task automatic cfg(input logic [2:0] ts, input logic [1:0] ic, input logic [2:0] m);
    bus(OFS_CON1, 1'b1, {19'h0, ts, 3'h0, ic, 2'h0, m});
  endtask : cfg

  // Mode off flushes the buffer before each capture case
  task automatic fresh(input logic [2:0] ts, input logic [1:0] ic, input logic [2:0] m);
    cfg(ts, ic, MODE_OFF);
    bus(OFS_STAT, 1'b1, 32'h3);
    cfg(ts, ic, m);
  endtask : fresh

  // Pops the oldest value, then n more; compares the span between them
  task automatic diffn(input int n, input logic [15:0] exp);
    logic [15:0] a;
    logic [15:0] dd;
    bus(OFS_BUF, 1'b0, 32'h0);
    a = rdq[15:0];
    repeat (n) bus(OFS_BUF, 1'b0, 32'h0);
    dd = rdq[15:0] - a;
    check({16'h0, dd}, {16'h0, exp});
  endtask : diffn

  task automatic irqchk(input logic e);
    @(negedge hclk);
    check({31'h0, irq}, {31'h0, e});
    @(posedge hclk);
  endtask : irqchk

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge hclk);
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(OFS_CON1, 32'hFFFFFFFF, 32'h0);
    rchk(OFS_CON2, 32'hFFFFFFFF, 32'h0000000D);
    rchk(OFS_STAT, 32'hFFFFFFFF, 32'h0);
    rchk(OFS_TMR, 32'hFFFFFFFF, 32'h0);
    bus(8'h40, 1'b1, 32'hFFFFFFFF);
    rchk(8'h40, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    // Free-running timer on the peripheral clock
    bus(OFS_CON2, 1'b1, 32'h0);
    bus(OFS_MASK, 1'b1, 32'h2);
    fresh(TSEL_PERIPH, 2'h0, MODE_RISE);
    capture_stimulus_inst.wave(5, 20);
    rchk(OFS_CON1, 32'h18, 32'h18);
    rchk(OFS_STAT, 32'h2, 32'h2);
    irqchk(1'b1);
    diffn(3, 16'd120);
    rchk(OFS_CON1, 32'h18, 32'h0);
    rchk(OFS_BUF, 32'hFFFFFFFF, 32'h0);
    $display("test rise and overflow done");
    fresh(TSEL_PERIPH, 2'h0, MODE_FALL);
    capture_stimulus_inst.wave(2, 20);
    diffn(1, 16'd40);
    rchk(OFS_CON1, 32'h8, 32'h0);
    fresh(TSEL_PERIPH, 2'h3, MODE_BOTH);
    capture_stimulus_inst.wave(1, 20);
    rchk(OFS_STAT, 32'h1, 32'h1);
    diffn(1, 16'd20);
    fresh(TSEL_PERIPH, 2'h3, MODE_PIN);
    capture_stimulus_inst.wave(1, 20);
    rchk(OFS_STAT, 32'h1, 32'h1);
    rchk(OFS_CON1, 32'h8, 32'h0);
    fresh(TSEL_PERIPH, 2'h0, MODE_OFF);
    capture_stimulus_inst.wave(1, 20);
    rchk(OFS_CON1, 32'h8, 32'h0);
    rchk(OFS_TMR, 32'hFFFF, 32'h0);
    $display("test edge modes done");
    for (int i = 0; i < 2; i++) begin
      fresh(TSEL_PERIPH, 2'h0, (i == 0) ? MODE_PRE4 : MODE_PRE16);
      capture_stimulus_inst.wave((i == 0) ? 3 : 15, 2);
      rchk(OFS_CON1, 32'h8, 32'h0);
      capture_stimulus_inst.wave(1, 2);
      rchk(OFS_CON1, 32'h8, 32'h8);
    end
    $display("test prescale done");
    bus(OFS_MASK, 1'b1, 32'h1);
    fresh(TSEL_PERIPH, 2'h2, MODE_RISE);
    capture_stimulus_inst.wave(2, 20);
    irqchk(1'b0);
    capture_stimulus_inst.wave(1, 20);
    irqchk(1'b1);
    bus(OFS_MASK, 1'b1, 32'h0);
    irqchk(1'b0);
    bus(OFS_MASK, 1'b1, 32'h1);
    irqchk(1'b1);
    bus(OFS_STAT, 1'b1, 32'h1);
    rchk(OFS_STAT, 32'h1, 32'h0);
    irqchk(1'b0);
    $display("test interrupt done");
    fresh(TSEL_T1, 2'h0, MODE_RISE);
    capture_stimulus_inst.wave(2, 20);
    diffn(1, 16'd10);
    fresh(TSEL_T2, 2'h0, MODE_RISE);
    capture_stimulus_inst.wave(2, 20);
    diffn(1, 16'd8);
    fresh(3'h2, 2'h0, MODE_RISE);
    rchk(OFS_TMR, 32'hFFFF, 32'h0);
    $display("test time base done");
    // Comparator codes are only ever used in trigger mode
    cfg(TSEL_PERIPH, 2'h0, MODE_RISE);
    for (int i = 0; i < 6; i++) begin
      bus(OFS_CON2, 1'b1, {24'h0, 3'b100, codes[i]});
      rchk(OFS_TMR, 32'hFFFF, 32'h0);
      capture_stimulus_inst.pulse(~evts[i]);
      rchk(OFS_CON2, 32'h40, 32'h0);
      capture_stimulus_inst.pulse(evts[i]);
      rchk(OFS_CON2, 32'h40, 32'h40);
      bus(OFS_TMR, 1'b0, 32'h0);
      check({31'h0, rdq[15:0] != 16'h0}, 32'h1);
      bus(OFS_CON2, 1'b1, {24'h0, 3'b100, codes[i]});
      rchk(OFS_TMR, 32'hFFFF, 32'h0);
      bus(OFS_CON2, 1'b1, {24'h0, 3'b110, codes[i]});
      rchk(OFS_CON2, 32'h40, 32'h40);
    end
    for (int i = 0; i < 2; i++) begin
      bus(OFS_CON2, 1'b1, {24'h0, 3'b100, (i == 0) ? SRC_NONE0 : SRC_NONE1});
      capture_stimulus_inst.pulse(6'h3F);
      rchk(OFS_CON2, 32'h40, 32'h0);
    end
    $display("test trigger done");
    bus(OFS_CON2, 1'b1, {24'h0, 3'b000, SRC_T2});
    repeat (60) @(posedge hclk);
    capture_stimulus_inst.pulse(6'h20);
    bus(OFS_TMR, 1'b0, 32'h0);
    check({31'h0, rdq[15:0] >= 16'd50}, 32'h1);
    capture_stimulus_inst.pulse(6'h10);
    bus(OFS_TMR, 1'b0, 32'h0);
    check({31'h0, rdq[15:0] < 16'd10}, 32'h1);
    $display("test sync done");
    wrap_up();
  end
endmodule : input_capture_channel_test
`default_nettype wire
